//--- verilog/lamp_chop_pkg.sv
package lamp_chop_pkg;
    // register byte offsets
    localparam logic [7:0] off_cfg_first = 8'h00;
    localparam logic [7:0] off_cfg_second = 8'h04;
    localparam logic [7:0] off_status = 8'h08;
    localparam logic [7:0] off_irq_status = 8'h0c;
    localparam logic [7:0] off_irq_mask = 8'h10;
    localparam logic [7:0] off_dev_addr = 8'h14;
    // configuration byte fields
    localparam int target_register_bit = 7;
    localparam int shdn_bit = 6;
    localparam int stdby_bit = 5;
    // status byte fields
    localparam int open_tube_ok_bit = 7;
    localparam logic [1:0] status_ones = 2'h3;
    // reset values
    localparam logic [6:0] cfg_reset = 7'h70;
    localparam logic [6:0] dev_addr_reset = 7'h2c;
    localparam logic [2:0] irq_mask_reset = 3'h0;
    // interrupt bits
    localparam int irq_cfg_write = 0;
    localparam int irq_open_tube = 1;
    localparam int irq_status_read = 2;
    localparam int irq_count = 3;
    // chopping
    localparam int chop_period = 1024;
    localparam int chop_cnt_w = 10;
    localparam logic [4:0] code_min_duty = 5'h03;
    localparam logic [4:0] code_full = 5'h1f;
    localparam int duty_step = 32;
    // link states
    typedef enum logic [2:0] {
        link_idle, link_addr, link_ack_addr, link_wdata, link_ack_wdata,
        link_rdata, link_ack_rdata, link_ignore
    } link_state_t;
endpackage : lamp_chop_pkg

//--- verilog/chop_pwm.sv
`timescale 1ns/1ps
module chop_pwm
    import lamp_chop_pkg::*;
#(
    parameter int period = chop_period,
    parameter int cnt_w = chop_cnt_w
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic [4:0] code,
    // phase
    output logic chop_on
);
    typedef struct packed {
        logic [cnt_w-1:0] cnt;
        logic on;
    } pwm_state_t;

    pwm_state_t state;
    pwm_state_t next_state;
    logic [cnt_w:0] thresh;

    always_comb begin
        next_state = state;
        // duty threshold from brightness code
        if (code == 5'h00) begin
            thresh = '0;
        end else if (code < code_min_duty) begin
            thresh = (cnt_w+1)'(code_min_duty * duty_step);
        end else begin
            thresh = (cnt_w+1)'(code * duty_step);
        end
        // free-running period counter
        if (state.cnt == cnt_w'(period - 1)) begin
            next_state.cnt = '0;
        end else begin
            next_state.cnt = state.cnt + 1'b1;
        end
        if (code == code_full) begin
            next_state.on = 1'b1;
        end else begin
            next_state.on = ({1'b0, next_state.cnt} < thresh);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign chop_on = state.on;
endmodule : chop_pwm

//--- verilog/lamp_chop_ctrl.sv
// Function
// - two 7-bit config registers; the latch-select pin picks the active one
// - config byte bit 7 high loads second register, low loads first
// - host reads status with read-byte; device returns one status byte
// - status bits 6,5 read one; low five show selected brightness code
// - open-tube-ok clears and latches on trip; set again in shutdown/standby
// - serial link keeps working during shutdown
// - shutdown-bar zero overrides the standby bit
// - chopping only with chop-mode strap high, else current scaling
// - soft-start chop output low in off interval, high in on interval
// - off interval forces switch off and compensation node high-impedance
// - chopping period is 1024 switching-clock cycles
// - duty set by 5-bit code in about 3% steps
// - full-scale code gives 100% duty
// - codes 1 to 3 give the same 9% minimum duty
// - code zero keeps the lamp off
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module lamp_chop_ctrl
    import lamp_chop_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // smbus link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // lamp pins
    input wire logic latch_select_pin,
    input wire logic chop_mode_strap,
    input wire logic open_tube_trip,
    output logic softstart_chop,
    output logic switch_force_off,
    output logic compensation_hiz,
    output logic shutdown_active,
    output logic standby_active,
    output logic [4:0] current_scale_code,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [1:0] sel_sync;
        logic [1:0] strap_sync;
        logic [1:0] trip_sync;
        logic trip_d;
        link_state_t link;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic [7:0] pend;
        logic pend_v;
        logic sda_oe;
        logic [6:0] cfg_first;
        logic [6:0] cfg_second;
        logic otok;
        logic [irq_count-1:0] irq_st;
        logic [irq_count-1:0] irq_mask;
        logic irq;
        logic [6:0] dev_addr;
        logic a_valid;
        logic a_write;
        logic [7:0] a_addr;
        logic rd_pend;
        logic ready;
        logic [31:0] hrdata;
        logic shutdown;
        logic standby;
        logic chop_en;
        logic softstart;
        logic sw_off;
        logic comp_hiz;
        logic [4:0] scale_code;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;
    logic chop_on;
    logic [6:0] cfg_sel;
    logic [7:0] status_byte;
    logic scl_rise;
    logic scl_fall;
    logic sda_now;
    logic start_cond;
    logic stop_cond;
    logic [irq_count-1:0] irq_set;
    logic [irq_count-1:0] irq_clr;

    chop_pwm #(
        .period(chop_period),
        .cnt_w(chop_cnt_w)
    ) u_chop (
        .hclk(hclk),
        .hresetn(hresetn),
        .code(cfg_sel[4:0]),
        .chop_on(chop_on)
    );

    always_comb begin
        next_state = state;
        irq_set = '0;
        irq_clr = '0;
        // pin synchronisers
        next_state.scl_sync = {state.scl_sync[1:0], scl_in};
        next_state.sda_sync = {state.sda_sync[1:0], sda_in};
        next_state.sel_sync = {state.sel_sync[0], latch_select_pin};
        next_state.strap_sync = {state.strap_sync[0], chop_mode_strap};
        next_state.trip_sync = {state.trip_sync[0], open_tube_trip};
        next_state.trip_d = state.trip_sync[1];
        // active register and status
        cfg_sel = state.sel_sync[1] ? state.cfg_second : state.cfg_first;
        status_byte = {state.otok, status_ones, cfg_sel[4:0]};
        // link edge detection
        sda_now = state.sda_sync[1];
        scl_rise = state.scl_sync[1] && !state.scl_sync[2];
        scl_fall = !state.scl_sync[1] && state.scl_sync[2];
        start_cond = state.scl_sync[1] && state.scl_sync[2] && !sda_now && state.sda_sync[2];
        stop_cond = state.scl_sync[1] && state.scl_sync[2] && sda_now && !state.sda_sync[2];
        // smbus slave, runs regardless of shutdown
        if (start_cond) begin
            next_state.link = link_addr;
            next_state.bitcnt = '0;
            next_state.pend_v = 1'b0;
            next_state.sda_oe = 1'b0;
        end else if (stop_cond) begin
            if (state.pend_v) begin
                if (state.pend[target_register_bit]) begin
                    next_state.cfg_second = state.pend[6:0];
                end else begin
                    next_state.cfg_first = state.pend[6:0];
                end
                irq_set[irq_cfg_write] = 1'b1;
            end
            next_state.pend_v = 1'b0;
            next_state.link = link_idle;
            next_state.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (state.link)
                link_addr, link_wdata: begin
                    next_state.shreg = {state.shreg[6:0], sda_now};
                    next_state.bitcnt = state.bitcnt + 4'h1;
                end
                link_ack_rdata: begin
                    if (sda_now) begin
                        next_state.link = link_ignore;
                    end else begin
                        next_state.link = link_ack_addr;
                        next_state.rw = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state.link)
                link_addr: begin
                    if (state.bitcnt == 4'h8) begin
                        if (state.shreg[7:1] == state.dev_addr) begin
                            next_state.sda_oe = 1'b1;
                            next_state.rw = state.shreg[0];
                            next_state.link = link_ack_addr;
                        end else begin
                            next_state.link = link_ignore;
                        end
                    end
                end
                link_ack_addr: begin
                    next_state.bitcnt = 4'h1;
                    if (state.rw) begin
                        next_state.shreg = status_byte;
                        next_state.sda_oe = !status_byte[7];
                        next_state.link = link_rdata;
                        irq_set[irq_status_read] = 1'b1;
                    end else begin
                        next_state.sda_oe = 1'b0;
                        next_state.bitcnt = '0;
                        next_state.link = link_wdata;
                    end
                end
                link_wdata: begin
                    if (state.bitcnt == 4'h8) begin
                        next_state.sda_oe = 1'b1;
                        next_state.pend = state.shreg;
                        next_state.pend_v = 1'b1;
                        next_state.link = link_ack_wdata;
                    end
                end
                link_ack_wdata: begin
                    next_state.sda_oe = 1'b0;
                    next_state.bitcnt = '0;
                    next_state.link = link_wdata;
                end
                link_rdata: begin
                    if (state.bitcnt == 4'h8) begin
                        next_state.sda_oe = 1'b0;
                        next_state.link = link_ack_rdata;
                    end else begin
                        next_state.shreg = {state.shreg[6:0], 1'b1};
                        next_state.sda_oe = !state.shreg[6];
                        next_state.bitcnt = state.bitcnt + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
        // mode decode
        next_state.shutdown = !cfg_sel[shdn_bit];
        next_state.standby = cfg_sel[shdn_bit] && !cfg_sel[stdby_bit];
        next_state.chop_en = state.strap_sync[1];
        // open-tube latch
        if (state.shutdown || state.standby) begin
            next_state.otok = 1'b1;
        end else if (state.trip_sync[1]) begin
            next_state.otok = 1'b0;
        end
        if (state.trip_sync[1] && !state.trip_d) begin
            irq_set[irq_open_tube] = 1'b1;
        end
        // lamp drive
        if (state.shutdown || state.standby) begin
            next_state.softstart = 1'b0;
            next_state.sw_off = 1'b1;
            next_state.comp_hiz = 1'b0;
            next_state.scale_code = '0;
        end else if (state.chop_en) begin
            next_state.softstart = chop_on;
            next_state.sw_off = !chop_on;
            next_state.comp_hiz = !chop_on;
            next_state.scale_code = code_full;
        end else begin
            next_state.softstart = 1'b1;
            next_state.sw_off = 1'b0;
            next_state.comp_hiz = 1'b0;
            next_state.scale_code = cfg_sel[4:0];
        end
        // ahb-lite data phase
        next_state.ready = 1'b1;
        if (state.a_valid && state.a_write) begin
            case (state.a_addr)
                off_irq_status: irq_clr = hwdata[irq_count-1:0];
                off_irq_mask: next_state.irq_mask = hwdata[irq_count-1:0];
                off_dev_addr: next_state.dev_addr = hwdata[6:0];
                default: begin
                end
            endcase
        end
        if (state.rd_pend) begin
            case (state.a_addr)
                off_cfg_first: next_state.hrdata = {25'h0, state.cfg_first};
                off_cfg_second: next_state.hrdata = {25'h0, state.cfg_second};
                off_status: next_state.hrdata = {21'h0, state.chop_en, state.standby, state.shutdown, status_byte};
                off_irq_status: next_state.hrdata = {29'h0, state.irq_st};
                off_irq_mask: next_state.hrdata = {29'h0, state.irq_mask};
                off_dev_addr: next_state.hrdata = {25'h0, state.dev_addr};
                default: next_state.hrdata = '0;
            endcase
        end
        next_state.rd_pend = 1'b0;
        if (state.ready) begin
            next_state.a_valid = hsel && htrans[1] && hready;
            next_state.a_write = hwrite;
            next_state.a_addr = haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                next_state.ready = 1'b0;
                next_state.rd_pend = 1'b1;
            end
        end else begin
            next_state.a_valid = 1'b0;
        end
        // sticky interrupts, set wins over clear
        next_state.irq_st = (state.irq_st & ~irq_clr) | irq_set;
        next_state.irq = |(next_state.irq_st & state.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
            state.scl_sync <= 3'h7;
            state.sda_sync <= 3'h7;
            state.link <= link_idle;
            state.cfg_first <= cfg_reset;
            state.cfg_second <= cfg_reset;
            state.otok <= 1'b1;
            state.irq_mask <= irq_mask_reset;
            state.dev_addr <= dev_addr_reset;
            state.ready <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign hrdata = state.hrdata;
    assign hreadyout = state.ready;
    assign hresp = 1'b0;
    assign sda_out = 1'b0;
    assign sda_oe = state.sda_oe;
    assign softstart_chop = state.softstart;
    assign switch_force_off = state.sw_off;
    assign compensation_hiz = state.comp_hiz;
    assign shutdown_active = state.shutdown;
    assign standby_active = state.standby;
    assign current_scale_code = state.scale_code;
    assign irq = state.irq;
endmodule : lamp_chop_ctrl

//--- dv/lamp_chop_properties.sv
`timescale 1ns/1ps
module lamp_chop_checker (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    // lamp
    input wire logic chop_mode_strap,
    input wire logic softstart_chop,
    input wire logic switch_force_off,
    input wire logic compensation_hiz,
    input wire logic shutdown_active,
    input wire logic standby_active
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_off_force;
        compensation_hiz |-> switch_force_off;
    endproperty
    a_off_force: assert property (p_off_force) else $error("switch not forced off in off phase");
    property p_ss_low;
        compensation_hiz |-> !softstart_chop;
    endproperty
    a_ss_low: assert property (p_ss_low) else $error("chop output high in off phase");
    property p_scaling;
        (!chop_mode_strap)[*6] |-> !compensation_hiz;
    endproperty
    a_scaling: assert property (p_scaling) else $error("chopping without strap");
    property p_shdn_prio;
        shutdown_active |-> !standby_active;
    endproperty
    a_shdn_prio: assert property (p_shdn_prio) else $error("standby beside shutdown");
    property p_shdn_off;
        shutdown_active && $past(shutdown_active) |-> switch_force_off && !softstart_chop;
    endproperty
    a_shdn_off: assert property (p_shdn_off) else $error("lamp running in shutdown");
    property p_min_on;
        $rose(softstart_chop) && $past(compensation_hiz) |-> (softstart_chop || shutdown_active || standby_active)[*8];
    endproperty
    a_min_on: assert property (p_min_on) else $error("on phase too short");
    property p_min_off;
        $fell(softstart_chop) && compensation_hiz |-> compensation_hiz[*8];
    endproperty
    a_min_off: assert property (p_min_off) else $error("off phase too short");
    property p_rd_wait;
        hsel && htrans[1] && hready && hreadyout && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
endmodule : lamp_chop_checker
bind lamp_chop_ctrl lamp_chop_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .chop_mode_strap(chop_mode_strap),
    .softstart_chop(softstart_chop), .switch_force_off(switch_force_off), .compensation_hiz(compensation_hiz),
    .shutdown_active(shutdown_active), .standby_active(standby_active));

//--- dv/smbus_host_model.sv
`timescale 1ns/1ps
module smbus_host_model
    import lamp_chop_pkg::*;
(
    // link pins
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic put_bit(input logic b, output logic r);
        #50 sda_low = !b;
        #150 scl = 1'b1;
        #150 r = sda;
        #50 scl = 1'b0;
    endtask : put_bit
    task automatic start_cond();
        #50 sda_low = 1'b0;
        #150 scl = 1'b1;
        #150 sda_low = 1'b1;
        #50 scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #50 sda_low = 1'b1;
        #150 scl = 1'b1;
        #150 sda_low = 1'b0;
        #200;
    endtask : stop_cond
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
        put_bit(1'b1, a);
        ack = !a;
    endtask : xfer
    task automatic write_cfg(input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic a1;
        logic a2;
        start_cond();
        xfer({dev_addr_reset, 1'b0}, q, a1);
        xfer(d, q, a2); // bit 7 picks the register
        stop_cond();
        ok = a1 & a2;
    endtask : write_cfg
    task automatic read_status(output logic [7:0] s, output logic ok);
        logic [7:0] q;
        logic a1;
        logic a2;
        logic a3;
        logic n;
        start_cond();
        xfer({dev_addr_reset, 1'b0}, q, a1); // command, repeated start, one byte
        xfer(8'h00, q, a2);
        start_cond();
        xfer({dev_addr_reset, 1'b1}, q, a3);
        xfer(8'hff, s, n);
        stop_cond();
        ok = a1 & a2 & a3;
    endtask : read_status
endmodule : smbus_host_model

//--- dv/testbench.sv
`timescale 1ns/1ps
`define check(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %s expected %h seen %h", name, exp, got); end end
module testbench
    import lamp_chop_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, sda_out, sda_oe, scl, host_sda_low, sda_wire, irq;
    logic latch_select_pin = 1'b0;
    logic chop_mode_strap = 1'b1;
    logic open_tube_trip = 1'b0;
    logic softstart_chop, switch_force_off, compensation_hiz, shutdown_active, standby_active;
    logic [4:0] current_scale_code;
    int failures = 0;
    int comparisons = 0;
    assign sda_wire = !host_sda_low && (sda_oe ? sda_out : 1'b1);
    always #25 hclk = ~hclk;
    lamp_chop_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .latch_select_pin(latch_select_pin), .chop_mode_strap(chop_mode_strap),
        .open_tube_trip(open_tube_trip), .softstart_chop(softstart_chop), .switch_force_off(switch_force_off),
        .compensation_hiz(compensation_hiz), .shutdown_active(shutdown_active), .standby_active(standby_active),
        .current_scale_code(current_scale_code), .irq(irq));
    smbus_host_model host (.scl(scl), .sda_low(host_sda_low), .sda(sda_wire));
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic wait_ready();
        int n;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin failures++; print_verdict(); end
    endtask : wait_ready
    task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : ahb
    task automatic reg_is(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(a, 1'b0, 32'h0, q);
        `check($sformatf("reg %h", a), e, q)
        `check("hresp", 1'b0, hresp)
    endtask : reg_is
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(a, 1'b1, d, q);
    endtask : reg_wr
    task automatic smb_write(input logic [7:0] d);
        logic ok;
        host.write_cfg(d, ok);
        `check("smbus ack", 1'b1, ok)
        repeat (20) @(posedge hclk);
    endtask : smb_write
    task automatic set_latch(input logic v);
        @(posedge hclk) latch_select_pin <= v;
        repeat (6) @(posedge hclk);
    endtask : set_latch
    task automatic wait_rise(output int n);
        logic p;
        n = 0;
        do begin p = softstart_chop; @(posedge hclk); n++; end
        while (!(softstart_chop === 1'b1 && p === 1'b0) && n < 3000);
        if (n >= 3000) begin
            failures++;
            print_verdict();
        end
    endtask : wait_rise
    task automatic measure(output int on_n, output int hiz_n);
        on_n = 0;
        hiz_n = 0;
        repeat (chop_period) begin
            @(posedge hclk);
            on_n += int'(softstart_chop === 1'b1);
            hiz_n += int'(compensation_hiz === 1'b1);
        end
    endtask : measure
    function automatic int exp_on(input logic [4:0] c);
        if (c == 5'h0) return 0;
        if (c == code_full) return chop_period;
        if (c <= code_min_duty) return int'(code_min_duty) * duty_step;
        return int'(c) * duty_step;
    endfunction : exp_on
    task automatic t_regs();
        reg_is(off_cfg_first, 32'h70);
        reg_is(off_cfg_second, 32'h70);
        reg_is(off_status, 32'h4f0);
        reg_is(off_dev_addr, 32'h2c);
        reg_is(8'h18, 32'h0);
        reg_wr(off_cfg_first, 32'h11);
        reg_is(off_cfg_first, 32'h70);
    endtask : t_regs
    task automatic t_cfg_sel();
        smb_write(8'hef);
        smb_write(8'h7f);
        reg_is(off_cfg_second, 32'h6f);
        reg_is(off_cfg_first, 32'h7f);
        reg_is(off_status, 32'h4ff);
        set_latch(1'b1);
        reg_is(off_status, 32'h4ef);
        set_latch(1'b0);
        `check("irq", 1'b0, irq)
        reg_is(off_irq_status, 32'h1);
        reg_wr(off_irq_mask, 32'h1);
        repeat (3) @(posedge hclk);
        `check("irq", 1'b1, irq)
        reg_wr(off_irq_status, 32'h7);
        repeat (3) @(posedge hclk);
        `check("irq", 1'b0, irq)
        reg_wr(off_irq_mask, 32'h0);
    endtask : t_cfg_sel
    task automatic t_smb_status();
        logic [7:0] s;
        logic ok;
        host.read_status(s, ok);
        `check("smbus ack", 1'b1, ok)
        `check("status byte", 8'hff, s)
    endtask : t_smb_status
    task automatic t_shutdown();
        smb_write(8'h00);
        `check("shutdown", 1'b1, shutdown_active)
        `check("standby", 1'b0, standby_active)
        `check("switch off", 1'b1, switch_force_off)
        smb_write(8'h70);
        `check("shutdown", 1'b0, shutdown_active)
        smb_write(8'h80);
        `check("shutdown", 1'b0, shutdown_active)
        set_latch(1'b1);
        `check("shutdown", 1'b1, shutdown_active)
        smb_write(8'hf0);
        `check("shutdown", 1'b0, shutdown_active)
        set_latch(1'b0);
    endtask : t_shutdown
    task automatic t_open_tube();
        @(posedge hclk) open_tube_trip <= 1'b1;
        repeat (10) @(posedge hclk);
        open_tube_trip <= 1'b0;
        repeat (10) @(posedge hclk);
        reg_is(off_status, 32'h470);
        reg_is(off_irq_status, 32'h7);
        smb_write(8'h50);
        `check("standby", 1'b1, standby_active)
        smb_write(8'h70);
        reg_is(off_status, 32'h4f0);
    endtask : t_open_tube
    task automatic t_duty();
        logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h03, 5'h10, 5'h1e, 5'h1f};
        int on_n;
        int hiz_n;
        foreach (codes[i]) begin
            smb_write({3'h3, codes[i]});
            measure(on_n, hiz_n);
            `check("on cycles", exp_on(codes[i]), on_n)
            `check("off cycles", chop_period - exp_on(codes[i]), hiz_n)
        end
        smb_write(8'h70);
        wait_rise(on_n);
        wait_rise(on_n);
        `check("period", chop_period, on_n)
        chop_mode_strap <= 1'b0;
        repeat (10) @(posedge hclk);
        measure(on_n, hiz_n);
        `check("scaling on", chop_period, on_n)
        `check("scaling code", 5'h10, current_scale_code)
        chop_mode_strap <= 1'b1;
    endtask : t_duty
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        t_regs();
        t_cfg_sel();
        t_smb_status();
        t_shutdown();
        t_open_tube();
        t_duty();
        print_verdict();
    end
endmodule : testbench
